// >>> inc/wdog_monitor_pkg.sv
// Purpose: shared constants and types for the watchdog service and monitor flag block
// Assumes: registers reached over AXI4-Lite, 32-bit data, one aligned word each
// Notes:   register byte address is four times its index
package wdog_monitor_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 6;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_WDOG_SERVICE = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_THERMAL_CTRL = 6'h10;
  localparam logic [IDX_W-1:0] IDX_SUPPLY_MON   = 6'h11;
  localparam logic [IDX_W-1:0] IDX_WDOG_CFG     = 6'h12;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS   = 6'h13;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE   = 6'h14;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR    = 6'h15;

  // ****************************************
  // field positions and values
  // ****************************************
  localparam int unsigned CHG_FLAG_BIT   = 0;
  localparam int unsigned IRQ_EN_BIT     = 1;
  localparam int unsigned DETECT_BIT     = 2;
  localparam int unsigned SENSE_EN_BIT   = 3;
  localparam int unsigned SRC_SEL_BIT    = 5;
  localparam int unsigned CFG_WINDOW_BIT = 7;
  localparam int unsigned RATE_W         = 3;
  localparam int unsigned EVT_THERMAL    = 0;
  localparam int unsigned EVT_SUPPLY     = 1;
  localparam int unsigned EVT_WDOG       = 2;
  localparam int unsigned CNT_W          = 18;
  localparam logic [7:0]  SERVICE_ARM    = 8'h55;
  localparam logic [7:0]  SERVICE_KICK   = 8'hAA;
  localparam logic [RATE_W-1:0] RATE_OFF = 3'h0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [7:0]  THERMAL_CTRL_RST = 8'h00;
  localparam logic [7:0]  SUPPLY_MON_RST   = 8'h00;
  localparam logic [7:0]  WDOG_CFG_RST     = 8'h00;
  localparam logic [2:0]  IRQ_ENABLE_RST   = 3'h0;
  // time-out as a power of two of clock cycles, rate codes 7 down to 1
  localparam logic [7:1][4:0] WDOG_SHIFT_DEFAULT =
    {5'h11, 5'h10, 5'h0F, 5'h0D, 5'h0B, 5'h09, 5'h07};

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [0:0] {
    SEQ_IDLE  = 1'b0,
    SEQ_ARMED = 1'b1
  } service_seq_t;

  typedef struct packed {
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] data;
    logic [3:0]        strb;
  } reg_write_t;

  typedef struct packed {
    logic thermal;
    logic supply;
  } detect_pair_t;

endpackage

// >>> src/wdog_monitor.sv
// Purpose: watchdog service sequencing plus thermal and low-supply monitor flags
// Assumes: detect inputs are asynchronous levels; reset controller takes a one-cycle request
// Notes:   AXI4-Lite slave, one write and one read outstanding
`timescale 1ns/1ps

module wdog_monitor
  import wdog_monitor_pkg::*;
#(
  parameter logic [7:1][4:0] WDOG_SHIFT = WDOG_SHIFT_DEFAULT
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              high_temp_detect,
  input  wire logic              low_supply_detect,
  output logic                   wdog_reset_req,
  output logic                   thermal_irq,
  output logic                   low_supply_irq,
  output logic                   irq,
  output logic                   sense_enable,
  output logic                   analog_source_select
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic mapped(input logic [IDX_W-1:0] idx);
    mapped = (idx >= IDX_WDOG_SERVICE) && (idx <= IDX_IRQ_CLEAR);
  endfunction

  // ****************************************
  // state declarations
  // ****************************************
  logic              aw_full_r,  aw_full_nxt;
  logic [IDX_W-1:0]  aw_idx_r,   aw_idx_nxt;
  logic              w_full_r,   w_full_nxt;
  logic [DATA_W-1:0] wdata_r,    wdata_nxt;
  logic [3:0]        wstrb_r,    wstrb_nxt;
  logic              awready_r,  awready_nxt;
  logic              wready_r,   wready_nxt;
  logic              bvalid_r,   bvalid_nxt;
  logic [1:0]        bresp_r,    bresp_nxt;
  logic              arready_r,  arready_nxt;
  logic              rvalid_r,   rvalid_nxt;
  logic [DATA_W-1:0] rdata_r,    rdata_nxt;
  logic [1:0]        rresp_r,    rresp_nxt;

  detect_pair_t      sync1_r,    sync1_nxt;
  detect_pair_t      sync2_r,    sync2_nxt;
  detect_pair_t      prev_r,     prev_nxt;
  logic              src_sel_r,  src_sel_nxt;
  logic              sense_en_r, sense_en_nxt;
  logic              therm_ie_r, therm_ie_nxt;
  logic              therm_fl_r, therm_fl_nxt;
  logic              sup_ie_r,   sup_ie_nxt;
  logic              sup_fl_r,   sup_fl_nxt;
  logic              wdog_ie_r,  wdog_ie_nxt;
  logic              wdog_ev_r,  wdog_ev_nxt;
  logic [RATE_W-1:0] rate_r,     rate_nxt;
  logic              window_r,   window_nxt;
  service_seq_t      seq_r,      seq_nxt;
  logic [CNT_W-1:0]  cnt_r,      cnt_nxt;
  logic              bite_r,     bite_nxt;
  logic              t_irq_r,    t_irq_nxt;
  logic              s_irq_r,    s_irq_nxt;
  logic              irq_r,      irq_nxt;

  logic              wr_fire;
  reg_write_t        wr_req;
  logic [DATA_W-1:0] rd_word;
  logic [CNT_W-1:0]  period;
  logic [CNT_W-1:0]  cnt_last;
  logic [CNT_W-1:0]  win_open;
  logic              svc_wr;
  logic              early;
  logic              timeout;
  logic              restart;

  assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
  assign wr_req  = '{idx: aw_idx_r, data: wdata_r, strb: wstrb_r};

  // ****************************************
  // register read mux
  // ****************************************
  always_comb begin
    rd_word = '0;
    case (araddr[ADDR_W-1:2])
      // service register has no readable state
      IDX_WDOG_SERVICE: rd_word = '0;
      IDX_THERMAL_CTRL: begin
        rd_word[SRC_SEL_BIT]  = src_sel_r;
        rd_word[SENSE_EN_BIT] = sense_en_r;
        rd_word[DETECT_BIT]   = sync2_r.thermal;
        rd_word[IRQ_EN_BIT]   = therm_ie_r;
        rd_word[CHG_FLAG_BIT] = therm_fl_r;
      end
      IDX_SUPPLY_MON: begin
        rd_word[DETECT_BIT]   = sync2_r.supply;
        rd_word[IRQ_EN_BIT]   = sup_ie_r;
        rd_word[CHG_FLAG_BIT] = sup_fl_r;
      end
      IDX_WDOG_CFG: begin
        rd_word[RATE_W-1:0]     = rate_r;
        rd_word[CFG_WINDOW_BIT] = window_r;
      end
      IDX_IRQ_STATUS: begin
        rd_word[EVT_THERMAL] = therm_fl_r;
        rd_word[EVT_SUPPLY]  = sup_fl_r;
        rd_word[EVT_WDOG]    = wdog_ev_r;
      end
      IDX_IRQ_ENABLE: begin
        rd_word[EVT_THERMAL] = therm_ie_r;
        rd_word[EVT_SUPPLY]  = sup_ie_r;
        rd_word[EVT_WDOG]    = wdog_ie_r;
      end
      default: rd_word = '0;
    endcase
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_idx_nxt  = aw_idx_r;
    w_full_nxt  = w_full_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (awvalid && awready_r) begin
      aw_full_nxt = 1'b1;
      aw_idx_nxt  = awaddr[ADDR_W-1:2];
    end
    if (wvalid && wready_r) begin
      w_full_nxt = 1'b1;
      wdata_nxt  = wdata;
      wstrb_nxt  = wstrb;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_fire) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    if (arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = rd_word;
      rresp_nxt   = mapped(araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_nxt = !aw_full_nxt;
    wready_nxt  = !w_full_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_idx_r  <= '0;
      w_full_r  <= 1'b0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      aw_idx_r  <= aw_idx_nxt;
      w_full_r  <= w_full_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ****************************************
  // watchdog period arithmetic
  // ****************************************
  always_comb begin
    if (rate_r == RATE_OFF) begin
      period = '0;
    end else begin
      period = CNT_W'(1) << WDOG_SHIFT[rate_r];
    end
    cnt_last = period - CNT_W'(1);
    win_open = period - (period >> 2);
  end

  // ****************************************
  // watchdog, monitor flags, interrupts
  // ****************************************
  always_comb begin
    sync1_nxt    = '{thermal: high_temp_detect, supply: low_supply_detect};
    sync2_nxt    = sync1_r;
    prev_nxt     = sync2_r;
    src_sel_nxt  = src_sel_r;
    sense_en_nxt = sense_en_r;
    therm_ie_nxt = therm_ie_r;
    sup_ie_nxt   = sup_ie_r;
    wdog_ie_nxt  = wdog_ie_r;
    rate_nxt     = rate_r;
    window_nxt   = window_r;
    seq_nxt      = seq_r;
    therm_fl_nxt = therm_fl_r;
    sup_fl_nxt   = sup_fl_r;
    wdog_ev_nxt  = wdog_ev_r;
    bite_nxt     = 1'b0;
    restart      = 1'b0;
    // disabled watchdog drops service writes
    svc_wr  = wr_fire && wr_req.strb[0] && (wr_req.idx == IDX_WDOG_SERVICE)
              && (rate_r != RATE_OFF);
    early   = window_r && (cnt_r < win_open);
    timeout = (rate_r != RATE_OFF) && (cnt_r == cnt_last);

    if (svc_wr) begin
      if (early) begin
        bite_nxt = 1'b1;
      end else if (wr_req.data[7:0] == SERVICE_ARM) begin
        seq_nxt = SEQ_ARMED;
      end else if (wr_req.data[7:0] == SERVICE_KICK) begin
        case (seq_r)
          SEQ_ARMED: begin
            restart = 1'b1;
            seq_nxt = SEQ_IDLE;
          end
          default: seq_nxt = seq_r;
        endcase
      end else begin
        bite_nxt = 1'b1;
      end
    end
    // a pair completed on the last cycle still counts
    if (timeout && !restart) begin
      bite_nxt = 1'b1;
    end

    if (wr_fire && wr_req.strb[0]) begin
      case (wr_req.idx)
        IDX_THERMAL_CTRL: begin
          src_sel_nxt  = wr_req.data[SRC_SEL_BIT];
          sense_en_nxt = wr_req.data[SENSE_EN_BIT];
          therm_ie_nxt = wr_req.data[IRQ_EN_BIT];
          if (wr_req.data[CHG_FLAG_BIT]) begin
            therm_fl_nxt = 1'b0;
          end
        end
        IDX_SUPPLY_MON: begin
          sup_ie_nxt = wr_req.data[IRQ_EN_BIT];
          if (wr_req.data[CHG_FLAG_BIT]) begin
            sup_fl_nxt = 1'b0;
          end
        end
        IDX_WDOG_CFG: begin
          rate_nxt   = wr_req.data[RATE_W-1:0];
          window_nxt = wr_req.data[CFG_WINDOW_BIT];
          restart    = 1'b1;
          seq_nxt    = SEQ_IDLE;
        end
        IDX_IRQ_ENABLE: begin
          therm_ie_nxt = wr_req.data[EVT_THERMAL];
          sup_ie_nxt   = wr_req.data[EVT_SUPPLY];
          wdog_ie_nxt  = wr_req.data[EVT_WDOG];
        end
        IDX_IRQ_CLEAR: begin
          if (wr_req.data[EVT_THERMAL]) begin
            therm_fl_nxt = 1'b0;
          end
          if (wr_req.data[EVT_SUPPLY]) begin
            sup_fl_nxt = 1'b0;
          end
          if (wr_req.data[EVT_WDOG]) begin
            wdog_ev_nxt = 1'b0;
          end
        end
        default: wdog_ev_nxt = wdog_ev_nxt;
      endcase
    end

    // set wins over a clear in the same cycle
    if (sync2_r.thermal != prev_r.thermal) begin
      therm_fl_nxt = 1'b1;
    end
    if (sync2_r.supply != prev_r.supply) begin
      sup_fl_nxt = 1'b1;
    end
    if (bite_nxt) begin
      wdog_ev_nxt = 1'b1;
      seq_nxt     = SEQ_IDLE;
    end

    if (bite_nxt || restart || (rate_nxt == RATE_OFF)) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
    t_irq_nxt = therm_fl_nxt && therm_ie_nxt;
    s_irq_nxt = sup_fl_nxt && sup_ie_nxt;
    irq_nxt   = t_irq_nxt || s_irq_nxt || (wdog_ev_nxt && wdog_ie_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      prev_r     <= '0;
      src_sel_r  <= THERMAL_CTRL_RST[SRC_SEL_BIT];
      sense_en_r <= THERMAL_CTRL_RST[SENSE_EN_BIT];
      therm_ie_r <= THERMAL_CTRL_RST[IRQ_EN_BIT];
      therm_fl_r <= THERMAL_CTRL_RST[CHG_FLAG_BIT];
      sup_ie_r   <= SUPPLY_MON_RST[IRQ_EN_BIT];
      sup_fl_r   <= SUPPLY_MON_RST[CHG_FLAG_BIT];
      wdog_ie_r  <= IRQ_ENABLE_RST[EVT_WDOG];
      wdog_ev_r  <= 1'b0;
      rate_r     <= WDOG_CFG_RST[RATE_W-1:0];
      window_r   <= WDOG_CFG_RST[CFG_WINDOW_BIT];
      seq_r      <= SEQ_IDLE;
      cnt_r      <= '0;
      bite_r     <= 1'b0;
      t_irq_r    <= 1'b0;
      s_irq_r    <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      sync1_r    <= sync1_nxt;
      sync2_r    <= sync2_nxt;
      prev_r     <= prev_nxt;
      src_sel_r  <= src_sel_nxt;
      sense_en_r <= sense_en_nxt;
      therm_ie_r <= therm_ie_nxt;
      therm_fl_r <= therm_fl_nxt;
      sup_ie_r   <= sup_ie_nxt;
      sup_fl_r   <= sup_fl_nxt;
      wdog_ie_r  <= wdog_ie_nxt;
      wdog_ev_r  <= wdog_ev_nxt;
      rate_r     <= rate_nxt;
      window_r   <= window_nxt;
      seq_r      <= seq_nxt;
      cnt_r      <= cnt_nxt;
      bite_r     <= bite_nxt;
      t_irq_r    <= t_irq_nxt;
      s_irq_r    <= s_irq_nxt;
      irq_r      <= irq_nxt;
    end
  end

  assign awready              = awready_r;
  assign wready               = wready_r;
  assign bvalid               = bvalid_r;
  assign bresp                = bresp_r;
  assign arready              = arready_r;
  assign rvalid               = rvalid_r;
  assign rdata                = rdata_r;
  assign rresp                = rresp_r;
  assign wdog_reset_req       = bite_r;
  assign thermal_irq          = t_irq_r;
  assign low_supply_irq       = s_irq_r;
  assign irq                  = irq_r;
  assign sense_enable         = sense_en_r;
  assign analog_source_select = src_sel_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_svc_read_zero: assert property (
    (arvalid && arready_r && araddr[ADDR_W-1:2] == IDX_WDOG_SERVICE) |=> (rdata_r == '0))
    else $error("service register read returned nonzero");
  a_disabled_no_bite: assert property (
    (svc_wr == 1'b0 && wr_fire && wr_req.idx == IDX_WDOG_SERVICE && rate_r == RATE_OFF)
    |=> !bite_r)
    else $error("write to disabled watchdog raised reset");
  a_bad_value_bite: assert property (
    (svc_wr && wr_req.data[7:0] != SERVICE_ARM && wr_req.data[7:0] != SERVICE_KICK)
    |=> bite_r ##1 !bite_r)
    else $error("illegal service value did not raise one reset pulse");
  a_pair_restart: assert property (
    (svc_wr && !early && seq_r == SEQ_ARMED && wr_req.data[7:0] == SERVICE_KICK)
    |=> (cnt_r == '0) && (seq_r == SEQ_IDLE) && !bite_r)
    else $error("completed service pair did not restart period");
  a_timeout_bite: assert property (
    (timeout && !svc_wr && !wr_fire) |=> bite_r && (cnt_r == '0))
    else $error("period end without service gave no reset");
  // a time-out in the same cycle is a legal reset, not a penalty
  a_arm_repeat: assert property (
    (svc_wr && !early && !timeout && wr_req.data[7:0] == SERVICE_ARM)
    |=> (seq_r == SEQ_ARMED) && !bite_r)
    else $error("arm write penalised or not armed");
  a_window_early: assert property (
    (svc_wr && window_r && cnt_r < win_open) |=> bite_r)
    else $error("early service in window mode gave no reset");
  a_therm_change: assert property (
    $changed(sync2_r.thermal) |=> therm_fl_r)
    else $error("thermal change flag not set on detect change");
  a_therm_hold: assert property (
    (therm_fl_r && !wr_fire) |=> therm_fl_r)
    else $error("thermal flag cleared without a write");
  a_supply_irq: assert property (
    (sup_fl_r && sup_ie_r) |-> s_irq_r)
    else $error("low-supply request missing while flag and enable set");
endmodule

// >>> bench/tb.sv
// Purpose: self-checking bench for the watchdog service and monitor flag block
// Assumes: every watchdog rate shortened to a 64-cycle period
// Notes:   bus answers are checked from queues by a separate watcher
`timescale 1ns/1ps

module tb;
  import wdog_monitor_pkg::*;

  // ****************************************
  // addresses and signals
  // ****************************************
  localparam logic [7:0] A_SVC = {IDX_WDOG_SERVICE, 2'b00};
  localparam logic [7:0] A_TH  = {IDX_THERMAL_CTRL, 2'b00};
  localparam logic [7:0] A_SM  = {IDX_SUPPLY_MON, 2'b00};
  localparam logic [7:0] A_CFG = {IDX_WDOG_CFG, 2'b00};
  localparam logic [7:0] A_ST  = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] A_EN  = {IDX_IRQ_ENABLE, 2'b00};
  localparam logic [7:0] A_CLR = {IDX_IRQ_CLEAR, 2'b00};
  localparam logic [7:0] A_BAD = 8'hFC;

  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              high_temp_detect, low_supply_detect, wdog_reset_req;
  logic              thermal_irq, low_supply_irq, irq, sense_enable, analog_source_select;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  logic [7:0]        bad;
  int                fail_count, tests_run, pulses, exp_pulses, seed;

  wdog_monitor #(.WDOG_SHIFT({7{5'h06}})) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .high_temp_detect(high_temp_detect), .low_supply_detect(low_supply_detect),
    .wdog_reset_req(wdog_reset_req), .thermal_irq(thermal_irq),
    .low_supply_irq(low_supply_irq), .irq(irq), .sense_enable(sense_enable),
    .analog_source_select(analog_source_select)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task report_and_stop;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tick(inout int k);
    k++;
    if (k > 200) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  always @(negedge aclk) begin
    if (wdog_reset_req === 1'b1) pulses++;
    if (bvalid === 1'b1 && bready === 1'b1) check("bresp", bresp, bq.pop_front());
    if (rvalid === 1'b1 && rready === 1'b1) check("rdata", {rresp, rdata}, rq.pop_front());
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic ra, rw, ta, tw;
    int   k;
    ta = 1'b0;
    tw = 1'b0;
    k = 0;
    bq.push_back(er);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ra = awready;
      rw = wready;
      @(posedge aclk);
      tick(k);
      if (ra === 1'b1 && !ta) begin ta = 1'b1; awvalid <= 1'b0; end
      if (rw === 1'b1 && !tw) begin tw = 1'b1; wvalid <= 1'b0; end
    end
    ra = 1'b0;
    while (ra !== 1'b1) begin
      @(negedge aclk);
      ra = bvalid;
      @(posedge aclk);
      tick(k);
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic r;
    int   k;
    k = 0;
    r = 1'b0;
    rq.push_back({er, 24'h000000, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (r !== 1'b1) begin
      @(negedge aclk);
      r = arready;
      @(posedge aclk);
      tick(k);
    end
    arvalid <= 1'b0;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge aclk);
      r = rvalid;
      @(posedge aclk);
      tick(k);
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wd_check;
    repeat (3) @(posedge aclk);
    check("wdog pulses", pulses, exp_pulses);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {high_temp_detect, low_supply_detect, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {fail_count, tests_run, pulses, exp_pulses} = '0;
    seed = 32'hb6ae;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_SVC, 8'h00);
    rd(A_BAD, 8'h00, RESP_SLVERR);
    wr(A_BAD, 8'h01, RESP_SLVERR);
    wr(A_TH, 8'h2A);
    rd(A_TH, 8'h2A);
    check("sense enable", sense_enable, 1);
    check("source select", analog_source_select, 1);
    high_temp_detect <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(A_TH, 8'h2F);
    check("thermal irq", {thermal_irq, irq}, 2'b11);
    wr(A_TH, 8'h2E);
    rd(A_TH, 8'h2F);
    wr(A_TH, 8'h28);
    check("thermal masked", thermal_irq, 0);
    wr(A_TH, 8'h29);
    rd(A_TH, 8'h2C);
    high_temp_detect <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(A_TH, 8'h29);
    wr(A_TH, 8'h01);
    rd(A_TH, 8'h00);
    check("sense off", {sense_enable, analog_source_select}, 2'b00);
    wstrb <= 4'hE;
    wr(A_TH, 8'h2A);
    wstrb <= 4'hF;
    rd(A_TH, 8'h00);
    wr(A_SM, 8'h06);
    rd(A_SM, 8'h02);
    low_supply_detect <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(A_SM, 8'h07);
    check("supply irq", low_supply_irq, 1);
    wr(A_SM, 8'h04);
    rd(A_SM, 8'h05);
    check("supply masked", low_supply_irq, 0);
    wr(A_SM, 8'h01);
    low_supply_detect <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(A_SM, 8'h01);
    wr(A_SM, 8'h01);
    wr(A_SVC, 8'h13);
    wd_check();
    wr(A_CFG, 8'h01);
    wr(A_SVC, SERVICE_KICK);
    wr(A_SVC, SERVICE_ARM);
    wr(A_SVC, SERVICE_ARM);
    wr(A_SVC, SERVICE_KICK);
    wr(A_SVC, SERVICE_ARM);
    wr(A_SVC, SERVICE_KICK);
    repeat (50) @(posedge aclk);
    wr(A_SVC, SERVICE_ARM);
    wr(A_SVC, SERVICE_KICK);
    wr(A_CFG, 8'h00);
    wd_check();
    bad = 8'($random(seed));
    if (bad == SERVICE_ARM || bad == SERVICE_KICK) bad = bad ^ 8'h01;
    wr(A_CFG, 8'h01);
    wr(A_SVC, bad);
    exp_pulses++;
    wr(A_CFG, 8'h00);
    wd_check();
    for (int c = 1; c < 8; c++) begin
      wr(A_CFG, 8'(c));
      repeat (70) @(posedge aclk);
      exp_pulses++;
      wr(A_CFG, 8'h00);
      wd_check();
    end
    wr(A_CFG, 8'h81);
    wr(A_SVC, SERVICE_ARM);
    exp_pulses++;
    wr(A_CFG, 8'h00);
    wd_check();
    wr(A_CFG, 8'h81);
    repeat (50) @(posedge aclk);
    wr(A_SVC, SERVICE_ARM);
    wr(A_SVC, SERVICE_KICK);
    wr(A_CFG, 8'h00);
    wd_check();
    rd(A_ST, 8'h04);
    wr(A_EN, 8'h04);
    check("irq raised", irq, 1);
    wr(A_CLR, 8'h04);
    check("irq cleared", irq, 0);
    rd(A_ST, 8'h00);
    rd(A_CLR, 8'h00);
    report_and_stop();
  end
endmodule
